// >>> design/access_permit.sv
// permission decision for one access against one page attribute word
`timescale 1ns/100ps
module access_permit
   import pmp_regs_pkg::*;
(
   // page attribute
   input  wire logic [PAGE_ATTR_W-1:0] attr_in,
   // access description
   input  wire logic                   local_in,
   input  wire logic [ID_W-1:0]        id_in,
   input  wire logic                   super_in,
   input  wire logic                   read_in,
   input  wire logic                   write_in,
   input  wire logic                   exec_in,
   // decision
   output      logic                   permit_out
);

   logic id_ok;
   logic type_ok;

   always_comb begin
      // requestor grant: local bit for cpu, aid bits below six, one bit for six and up
      if (local_in) begin
         id_ok = attr_in[LOCAL_GRANT_BIT];
      end else if (id_in >= HIGH_ID_MIN) begin
         id_ok = attr_in[HIGH_ID_GRANT_BIT];
      end else begin
         id_ok = attr_in[ID_GRANT_LSB + int'(id_in[2:0])];
      end
      // every requested access type must be allowed
      if (super_in) begin
         type_ok = (!read_in  || attr_in[SUPER_READ_PERM]) &&
                   (!write_in || attr_in[SUPER_WRITE_PERM]) &&
                   (!exec_in  || attr_in[SUPER_EXEC_PERM]);
      end else begin
         type_ok = (!read_in  || attr_in[USER_READ_PERM]) &&
                   (!write_in || attr_in[USER_WRITE_PERM]) &&
                   (!exec_in  || attr_in[USER_EXEC_PERM]);
      end
      permit_out = id_ok && type_ok;
   end

endmodule

// >>> design/program_memory_protection_regs.sv
// protection registers, key lock and fault capture of the program memory protection unit
`timescale 1ns/100ps
module program_memory_protection_regs
   import pmp_regs_pkg::*;
(
   // clock, reset, enable
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  ce_in,
   // register port
   input  wire logic                  reg_req_in,
   input  wire logic                  reg_write_in,
   input  wire logic                  reg_super_in,
   input  wire logic [31:0]           reg_addr_in,
   input  wire logic [31:0]           reg_wdata_in,
   output      logic                  reg_ack_out,
   output      logic                  reg_err_out,
   output      logic [31:0]           reg_rdata_out,
   // memory access check port
   input  wire logic                  acc_req_in,
   input  wire logic [31:0]           acc_addr_in,
   input  wire logic [PAGE_IDX_W-1:0] acc_page_in,
   input  wire logic                  acc_local_in,
   input  wire logic [ID_W-1:0]       acc_id_in,
   input  wire logic                  acc_super_in,
   input  wire logic                  acc_read_in,
   input  wire logic                  acc_write_in,
   input  wire logic                  acc_exec_in,
   output      logic                  acc_ack_out,
   output      logic                  acc_grant_out,
   // exception events and status
   output      logic                  cpu_fault_event_out,
   output      logic                  dma_fault_event_out,
   output      logic                  lock_engaged_out,
   output      logic                  fault_pending_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      lock_state_t                                lock;
      logic [KEY_W-1:0]                           stored_key;
      logic [KEY_W-1:0]                           entry_key;
      logic [KEY_WORDS-1:0]                       key_seen;
      logic [PAGE_COUNT-1:0][PAGE_ATTR_W-1:0]     page;
      logic                                       fault_held;
      logic                                       fault_local;
      logic [31:0]                                fault_addr;
      logic [15:0]                                fault_stat;
      logic                                       reg_ack;
      logic                                       reg_err;
      logic [31:0]                                reg_rdata;
      logic                                       acc_ack;
      logic                                       acc_grant;
      logic                                       cpu_evt;
      logic                                       dma_evt;
   } state_t;

   state_t st;
   state_t next_st;

   logic                 permit;
   logic                 clear_req;
   logic                 reg_fault;
   logic [15:0]          reg_fault_stat;
   logic                 new_valid;
   logic                 new_local;
   logic [31:0]          new_addr;
   logic [15:0]          new_stat;
   logic                 accept;

   ////////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic page_hit(input logic [31:0] addr);
      page_hit = (addr[31:PAGE_BASE_LSB] == ADDR_PAGE_BASE[31:PAGE_BASE_LSB]) &&
                 (addr[PAGE_IDX_LSB-1:0] == 2'h0);
   endfunction

   function automatic logic [PAGE_IDX_W-1:0] page_index(input logic [31:0] addr);
      page_index = addr[PAGE_BASE_LSB-1:PAGE_IDX_LSB];
   endfunction

   function automatic logic is_mapped(input logic [31:0] addr);
      case (addr)
         ADDR_FAULT_ADDRESS, ADDR_FAULT_STATUS, ADDR_FAULT_CLEAR,
         ADDR_LOCK_KEY0, ADDR_LOCK_KEY1, ADDR_LOCK_KEY2, ADDR_LOCK_KEY3,
         ADDR_LOCK_COMMAND, ADDR_LOCK_STATUS: begin
            is_mapped = 1'b1;
         end
         default: begin
            is_mapped = page_hit(addr);
         end
      endcase
   endfunction

   // fault status word; local faults carry a zero id
   function automatic logic [15:0] make_status(input logic            local_acc,
                                               input logic [ID_W-1:0] id,
                                               input logic            super_acc,
                                               input logic            rd,
                                               input logic            wr);
      logic [15:0] s;
      s = 16'h0000;
      if (local_acc) begin
         s[FAULT_LOCAL_BIT] = 1'b1;
      end else begin
         s[FAULT_ID_LSB +: FAULT_ID_W] = id[FAULT_ID_W-1:0];
      end
      s[FAULT_SUPER_READ]  = super_acc && rd;
      s[FAULT_SUPER_WRITE] = super_acc && wr;
      s[FAULT_USER_READ]   = !super_acc && rd;
      s[FAULT_USER_WRITE]  = !super_acc && wr;
      make_status = s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // permission check of the addressed page

   access_permit u_permit (
      .attr_in    (st.page[acc_page_in]),
      .local_in   (acc_local_in),
      .id_in      (acc_id_in),
      .super_in   (acc_super_in),
      .read_in    (acc_read_in),
      .write_in   (acc_write_in),
      .exec_in    (acc_exec_in),
      .permit_out (permit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_st     = st;
      next_st.reg_ack = 1'b0;
      next_st.reg_err = 1'b0;
      next_st.acc_ack = 1'b0;
      next_st.cpu_evt = 1'b0;
      next_st.dma_evt = 1'b0;
      clear_req   = 1'b0;
      reg_fault   = 1'b0;
      reg_fault_stat = make_status(1'b1, '0, reg_super_in, 1'b0, 1'b1);

      // register port
      if (reg_req_in) begin
         next_st.reg_ack   = 1'b1;
         next_st.reg_rdata = 32'h0000_0000;
         if (!reg_write_in) begin
            case (reg_addr_in)
               ADDR_FAULT_ADDRESS: begin
                  next_st.reg_rdata = st.fault_addr;
               end
               ADDR_FAULT_STATUS: begin
                  next_st.reg_rdata = {16'h0000, st.fault_stat};
               end
               ADDR_LOCK_STATUS: begin
                  next_st.reg_rdata[LOCK_ENGAGED_BIT] = (st.lock == lock_shut);
               end
               ADDR_FAULT_CLEAR, ADDR_LOCK_KEY0, ADDR_LOCK_KEY1, ADDR_LOCK_KEY2,
               ADDR_LOCK_KEY3, ADDR_LOCK_COMMAND: begin
                  next_st.reg_rdata = 32'h0000_0000;
               end
               default: begin
                  if (page_hit(reg_addr_in)) begin
                     next_st.reg_rdata = {16'h0000, st.page[page_index(reg_addr_in)]};
                  end else begin
                     next_st.reg_err = 1'b1;
                  end
               end
            endcase
         end else if (!reg_super_in) begin
            // user writes are refused; a mapped target is a cpu fault
            next_st.reg_err = 1'b1;
            reg_fault       = is_mapped(reg_addr_in);
         end else begin
            case (reg_addr_in)
               ADDR_FAULT_CLEAR: begin
                  clear_req = reg_wdata_in[FAULT_CLEAR_CMD_BIT];
               end
               ADDR_LOCK_KEY0: begin
                  next_st.entry_key[31:0] = reg_wdata_in;
                  next_st.key_seen[0]     = 1'b1;
               end
               ADDR_LOCK_KEY1: begin
                  next_st.entry_key[63:32] = reg_wdata_in;
                  next_st.key_seen[1]      = 1'b1;
               end
               ADDR_LOCK_KEY2, ADDR_LOCK_KEY3: begin
                  next_st.entry_key = st.entry_key;
               end
               ADDR_LOCK_COMMAND: begin
                  if (reg_wdata_in[KEY_STATUS_RESET_BIT]) begin
                     next_st.key_seen = '0;
                  end else if (reg_wdata_in[LOCK_CMD_BIT]) begin
                     next_st.key_seen = '0;
                     if (st.lock == lock_open && &st.key_seen) begin
                        next_st.stored_key = st.entry_key;
                        next_st.lock       = lock_shut;
                     end
                  end else if (reg_wdata_in[UNLOCK_CMD_BIT]) begin
                     next_st.key_seen = '0;
                     if (st.lock == lock_shut && &st.key_seen &&
                         st.entry_key == st.stored_key) begin
                        next_st.lock = lock_open;
                     end
                  end
               end
               ADDR_FAULT_ADDRESS, ADDR_FAULT_STATUS, ADDR_LOCK_STATUS: begin
                  next_st.reg_err = 1'b0;
               end
               default: begin
                  if (!page_hit(reg_addr_in)) begin
                     next_st.reg_err = 1'b1;
                  end else if (st.lock == lock_shut) begin
                     next_st.reg_err = 1'b1;
                     reg_fault       = 1'b1;
                  end else begin
                     next_st.page[page_index(reg_addr_in)] =
                        reg_wdata_in[PAGE_ATTR_W-1:0] & PAGE_WRITE_MASK;
                  end
               end
            endcase
         end
      end

      // access check port
      if (acc_req_in) begin
         next_st.acc_ack   = 1'b1;
         next_st.acc_grant = permit;
      end

      // fault candidate: local access fault, then register fault, then dma fault
      new_valid = 1'b0;
      new_local = 1'b0;
      new_addr  = acc_addr_in;
      new_stat  = make_status(acc_local_in, acc_id_in, acc_super_in, acc_read_in,
                              acc_write_in);
      if (acc_req_in && !permit && acc_local_in) begin
         new_valid = 1'b1;
         new_local = 1'b1;
      end else if (reg_fault) begin
         new_valid = 1'b1;
         new_local = 1'b1;
         new_addr  = reg_addr_in;
         new_stat  = reg_fault_stat;
      end else if (acc_req_in && !permit) begin
         new_valid = 1'b1;
      end

      // first fault only, except a local fault over a remote one
      accept = new_valid &&
               (!st.fault_held || clear_req ||
                (new_local && !st.fault_local));

      if (clear_req) begin
         next_st.fault_held  = 1'b0;
         next_st.fault_local = 1'b0;
         next_st.fault_addr  = 32'h0000_0000;
         next_st.fault_stat  = 16'h0000;
      end
      // a fault in the clearing cycle is kept
      if (accept) begin
         next_st.fault_held  = 1'b1;
         next_st.fault_local = new_local;
         next_st.fault_addr  = new_addr;
         next_st.fault_stat  = new_stat;
         next_st.cpu_evt     = new_local;
         next_st.dma_evt     = !new_local;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_ack_out         = st.reg_ack;
   assign reg_err_out         = st.reg_err;
   assign reg_rdata_out       = st.reg_rdata;
   assign acc_ack_out         = st.acc_ack;
   assign acc_grant_out       = st.acc_grant;
   assign cpu_fault_event_out = st.cpu_evt;
   assign dma_fault_event_out = st.dma_evt;
   assign lock_engaged_out    = (st.lock == lock_shut);
   assign fault_pending_out   = st.fault_held;

endmodule

// >>> pkg/pmp_regs_pkg.sv
// register map, field layout and widths of the program memory protection registers
package pmp_regs_pkg;

   // register byte addresses
   localparam logic [31:0] ADDR_FAULT_ADDRESS = 32'h0184a400;
   localparam logic [31:0] ADDR_FAULT_STATUS  = 32'h0184a404;
   localparam logic [31:0] ADDR_FAULT_CLEAR   = 32'h0184a408;
   localparam logic [31:0] ADDR_LOCK_KEY0     = 32'h0184a500;
   localparam logic [31:0] ADDR_LOCK_KEY1     = 32'h0184a504;
   localparam logic [31:0] ADDR_LOCK_KEY2     = 32'h0184a508;
   localparam logic [31:0] ADDR_LOCK_KEY3     = 32'h0184a50c;
   localparam logic [31:0] ADDR_LOCK_COMMAND  = 32'h0184a510;
   localparam logic [31:0] ADDR_LOCK_STATUS   = 32'h0184a514;
   localparam logic [31:0] ADDR_PAGE_BASE     = 32'h0184a600;

   // page table geometry
   localparam int PAGE_COUNT    = 32;
   localparam int PAGE_IDX_W    = 5;
   localparam int PAGE_IDX_LSB  = 2;
   localparam int PAGE_BASE_LSB = PAGE_IDX_LSB + PAGE_IDX_W;
   localparam int PAGE_ATTR_W   = 16;

   // page attribute fields
   localparam int ID_GRANT_LSB       = 10;
   localparam int HIGH_ID_GRANT_BIT  = 9;
   localparam int LOCAL_GRANT_BIT    = 8;
   localparam int SUPER_READ_PERM    = 5;
   localparam int SUPER_WRITE_PERM   = 4;
   localparam int SUPER_EXEC_PERM    = 3;
   localparam int USER_READ_PERM     = 2;
   localparam int USER_WRITE_PERM    = 1;
   localparam int USER_EXEC_PERM     = 0;
   localparam logic [15:0] PAGE_WRITE_MASK = 16'hff3f;

   // requestor ids
   localparam int ID_W = 8;
   localparam logic [ID_W-1:0] HIGH_ID_MIN = 8'h06;

   // lock key
   localparam int KEY_WORDS = 2;
   localparam int KEY_W     = 64;

   // lock command and status fields
   localparam int KEY_STATUS_RESET_BIT = 2;
   localparam int LOCK_CMD_BIT         = 1;
   localparam int UNLOCK_CMD_BIT       = 0;
   localparam int LOCK_ENGAGED_BIT     = 0;

   // fault status and clear fields
   localparam int FAULT_ID_LSB        = 9;
   localparam int FAULT_ID_W          = 7;
   localparam int FAULT_LOCAL_BIT     = 8;
   localparam int FAULT_SUPER_READ    = 5;
   localparam int FAULT_SUPER_WRITE   = 4;
   localparam int FAULT_USER_READ     = 2;
   localparam int FAULT_USER_WRITE    = 1;
   localparam int FAULT_CLEAR_CMD_BIT = 0;

   typedef enum logic [0:0] {
      lock_open,
      lock_shut
   } lock_state_t;

endpackage

// >>> testbench/access_requestor.sv
// cpu and dma requestor model driving the access check port
`timescale 1ns/100ps
module access_requestor
   import pmp_regs_pkg::*;
(
   // clock
   input  wire logic                  clk_in,
   // access check port
   output      logic                  acc_req_out,
   output      logic [31:0]           acc_addr_out,
   output      logic [PAGE_IDX_W-1:0] acc_page_out,
   output      logic                  acc_local_out,
   output      logic [ID_W-1:0]       acc_id_out,
   output      logic [3:0]            acc_type_out,
   input  wire logic                  acc_ack_in,
   input  wire logic                  acc_grant_in
);
   initial begin
      acc_req_out = 1'b0;
      acc_addr_out = 32'h0;
      acc_page_out = '0;
      acc_local_out = 1'b0;
      acc_id_out = '0;
      acc_type_out = 4'h0;
   end
   // type is super, read, write, exec; request held for one cycle, one request per two cycles
   task automatic access(input logic loc, input logic [ID_W-1:0] id, input logic [3:0] typ,
                         input logic [PAGE_IDX_W-1:0] page, input logic [31:0] addr,
                         output logic ack, output logic grant);
      @(negedge clk_in);
      acc_req_out = 1'b1;
      acc_local_out = loc;
      acc_id_out = id;
      acc_type_out = typ;
      acc_page_out = page;
      acc_addr_out = addr;
      @(negedge clk_in);
      acc_req_out = 1'b0;
      // released address, id and type lines no longer show the request; page and local lines keep it
      acc_addr_out = ~addr;
      acc_id_out = ~id;
      acc_type_out = ~typ;
      ack = acc_ack_in;
      grant = acc_grant_in;
   endtask
endmodule

// >>> testbench/program_memory_protection_regs_bench.sv
// self-checking bench for the program memory protection registers
`timescale 1ns/100ps
module program_memory_protection_regs_bench
   import pmp_regs_pkg::*;
   ;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        ce_in = 1'b1;
   logic        reg_req_in = 1'b0;
   logic        reg_write_in = 1'b0;
   logic        reg_super_in = 1'b0;
   logic [31:0] reg_addr_in = 32'h0;
   logic [31:0] reg_wdata_in = 32'h0;
   logic [31:0] reg_rdata_out, acc_addr_in, q;
   logic [3:0]  acc_type;
   logic [4:0]  acc_page_in;
   logic [7:0]  acc_id_in;
   logic        reg_ack_out, reg_err_out, acc_req_in, acc_local_in, acc_ack_out, acc_grant_out;
   logic        cpu_fault_event_out, dma_fault_event_out, lock_engaged_out, fault_pending_out;
   logic        e, a, g;
   int          mismatches = 0;
   int          cmp_count = 0;
   localparam logic [31:0] KEY_LO = 32'h1234abcd;
   localparam logic [31:0] KEY_HI = 32'h5a5a0f0f;
   // local, id, type, page per granted access
   localparam logic [17:0] GRANTS [4] = '{{1'b0, 8'h06, 4'h4, 5'h2}, {1'b0, 8'h07, 4'ha, 5'h2},
                                         {1'b0, 8'h02, 4'h4, 5'h2}, {1'b1, 8'h00, 4'h2, 5'h4}};
   always #50 clk_in = ~clk_in;
   program_memory_protection_regs DUT (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_req_in(reg_req_in),
      .reg_write_in(reg_write_in), .reg_super_in(reg_super_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_ack_out(reg_ack_out), .reg_err_out(reg_err_out),
      .reg_rdata_out(reg_rdata_out), .acc_req_in(acc_req_in), .acc_addr_in(acc_addr_in),
      .acc_page_in(acc_page_in), .acc_local_in(acc_local_in), .acc_id_in(acc_id_in),
      .acc_super_in(acc_type[3]), .acc_read_in(acc_type[2]), .acc_write_in(acc_type[1]),
      .acc_exec_in(acc_type[0]), .acc_ack_out(acc_ack_out), .acc_grant_out(acc_grant_out),
      .cpu_fault_event_out(cpu_fault_event_out), .dma_fault_event_out(dma_fault_event_out),
      .lock_engaged_out(lock_engaged_out), .fault_pending_out(fault_pending_out));
   access_requestor req (
      .clk_in(clk_in), .acc_req_out(acc_req_in), .acc_addr_out(acc_addr_in),
      .acc_page_out(acc_page_in), .acc_local_out(acc_local_in), .acc_id_out(acc_id_in),
      .acc_type_out(acc_type), .acc_ack_in(acc_ack_out), .acc_grant_in(acc_grant_out));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic reg_io(input logic wr, input logic [31:0] ad, input logic [31:0] d);
      @(negedge clk_in);
      reg_req_in = 1'b1;
      reg_write_in = wr;
      reg_super_in = 1'b1;
      reg_addr_in = ad;
      reg_wdata_in = d;
      @(negedge clk_in);
      reg_req_in = 1'b0;
      reg_addr_in = ~ad;
      reg_wdata_in = ~d;
      check({31'h0, reg_ack_out}, 32'h1);
      q = reg_rdata_out;
      e = reg_err_out;
   endtask
   task automatic wchk(input logic [31:0] ad, input logic [31:0] d, input logic ee);
      reg_io(1'b1, ad, d);
      check({31'h0, e}, {31'h0, ee});
   endtask
   task automatic rchk(input logic [31:0] ad, input logic [31:0] exp);
      reg_io(1'b0, ad, 32'h0);
      check(q, exp);
   endtask
   function automatic logic [31:0] pg(input logic [4:0] n);
      return ADDR_PAGE_BASE | ({27'h0, n} << PAGE_IDX_LSB);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      rchk(ADDR_LOCK_STATUS, 32'h0);
      wchk(pg(5'h3), 32'hffffffff, 1'b0);
      rchk(pg(5'h3), 32'h0000ff3f);
      wchk(pg(5'h2), 32'h00001214, 1'b0);
      wchk(pg(5'h4), 32'h00000102, 1'b0);
      for (int i = 0; i < 4; i++) begin
         req.access(GRANTS[i][17], GRANTS[i][16:9], GRANTS[i][8:5], GRANTS[i][4:0], 32'h100, a, g);
         check({30'h0, a, g}, 32'h3);
      end
      req.access(1'b0, 8'h85, 4'h2, 5'h2, 32'h00c0ffee, a, g);
      check({29'h0, a, g, dma_fault_event_out}, 32'h5);
      rchk(ADDR_FAULT_ADDRESS, 32'h00c0ffee);
      rchk(ADDR_FAULT_STATUS, 32'h00000a02);
      req.access(1'b0, 8'h03, 4'h4, 5'h2, 32'h11112222, a, g);
      check({30'h0, g, dma_fault_event_out}, 32'h0);
      rchk(ADDR_FAULT_STATUS, 32'h00000a02);
      req.access(1'b1, 8'h7f, 4'hc, 5'h2, 32'h00003330, a, g);
      check({30'h0, g, cpu_fault_event_out}, 32'h1);
      rchk(ADDR_FAULT_STATUS, 32'h00000120);
      wchk(ADDR_FAULT_CLEAR, 32'h0, 1'b0);
      rchk(ADDR_FAULT_STATUS, 32'h00000120);
      wchk(ADDR_FAULT_CLEAR, 32'h1, 1'b0);
      rchk(ADDR_FAULT_STATUS, 32'h0);
      check({31'h0, fault_pending_out}, 32'h0);
      wchk(ADDR_LOCK_KEY0, KEY_LO, 1'b0);
      wchk(ADDR_LOCK_KEY1, KEY_HI, 1'b0);
      wchk(ADDR_LOCK_KEY2, 32'h0bad0001, 1'b0);
      wchk(ADDR_LOCK_COMMAND, 32'h2, 1'b0);
      rchk(ADDR_LOCK_STATUS, 32'h1);
      wchk(pg(5'h3), 32'h0, 1'b1);
      rchk(pg(5'h3), 32'h0000ff3f);
      rchk(ADDR_FAULT_STATUS, 32'h00000110);
      wchk(ADDR_FAULT_CLEAR, 32'h1, 1'b0);
      wchk(ADDR_LOCK_KEY0, KEY_LO, 1'b0);
      wchk(ADDR_LOCK_KEY1, KEY_HI, 1'b0);
      wchk(ADDR_LOCK_COMMAND, 32'h4, 1'b0);
      wchk(ADDR_LOCK_COMMAND, 32'h1, 1'b0);
      rchk(ADDR_LOCK_STATUS, 32'h1);
      wchk(ADDR_LOCK_KEY0, KEY_LO, 1'b0);
      wchk(ADDR_LOCK_KEY1, ~KEY_HI, 1'b0);
      wchk(ADDR_LOCK_COMMAND, 32'h1, 1'b0);
      rchk(ADDR_LOCK_STATUS, 32'h1);
      wchk(ADDR_LOCK_KEY0, KEY_LO, 1'b0);
      wchk(ADDR_LOCK_KEY1, KEY_HI, 1'b0);
      wchk(ADDR_LOCK_KEY3, 32'h0bad0bad, 1'b0);
      wchk(ADDR_LOCK_COMMAND, 32'h0, 1'b0);
      wchk(ADDR_LOCK_COMMAND, 32'h1, 1'b0);
      rchk(ADDR_LOCK_STATUS, 32'h0);
      rchk(ADDR_LOCK_KEY0, 32'h0);
      reg_io(1'b0, 32'h0184a700, 32'h0);
      check({31'h0, e}, 32'h1);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      mismatches = mismatches + 1;
      stop_test();
   end
endmodule

// >>> testbench/program_memory_protection_regs_checker.sv
// concurrent checks on the protection register block ports
`timescale 1ns/100ps
module program_memory_protection_regs_checker
   import pmp_regs_pkg::*;
(
   // clock, reset, enable
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        ce_in,
   // register port
   input wire logic        reg_req_in,
   input wire logic        reg_write_in,
   input wire logic        reg_super_in,
   input wire logic [31:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_ack_out,
   input wire logic        reg_err_out,
   input wire logic [31:0] reg_rdata_out,
   // access port
   input wire logic        acc_req_in,
   input wire logic        acc_local_in,
   input wire logic        acc_ack_out,
   input wire logic        acc_grant_out,
   // events and status
   input wire logic        cpu_fault_event_out,
   input wire logic        dma_fault_event_out,
   input wire logic        lock_engaged_out,
   input wire logic        fault_pending_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire logic sup_wr  = reg_req_in && reg_write_in && reg_super_in;
   wire logic clr_wr  = sup_wr && reg_addr_in == ADDR_FAULT_CLEAR && reg_wdata_in[0];
   wire logic page_wr = sup_wr && reg_addr_in[31:7] == ADDR_PAGE_BASE[31:7]
                        && reg_addr_in[1:0] == 2'h0;
   wire logic stat_rd = reg_req_in && !reg_write_in && reg_addr_in == ADDR_LOCK_STATUS;
   wire logic fsr_rd  = reg_req_in && !reg_write_in && reg_addr_in == ADDR_FAULT_STATUS;
   wire logic loc_req = acc_req_in && acc_local_in;
   ////////////////////////////////////////////////////////////////////////////////
   reg_answer_a: assert property (ce_in && reg_req_in |=> reg_ack_out)
      else $error("register request not answered");
   acc_answer_a: assert property (ce_in && acc_req_in |=> acc_ack_out)
      else $error("access request not answered");
   lock_blocks_a: assert property (ce_in && page_wr && lock_engaged_out
      |=> reg_err_out && fault_pending_out)
      else $error("page write passed while locked");
   lock_status_a: assert property (reg_ack_out && !reg_err_out && $past(stat_rd)
      |-> reg_rdata_out == {31'h0, lock_engaged_out})
      else $error("lock status read wrong");
   status_fields_a: assert property (reg_ack_out && $past(fsr_rd)
      |-> reg_rdata_out[31:16] == 16'h0 && reg_rdata_out[7:6] == 2'h0
          && !reg_rdata_out[3] && !reg_rdata_out[0]
          && (!reg_rdata_out[8] || reg_rdata_out[15:9] == 7'h0))
      else $error("fault status reserved or id field wrong");
   single_fault_a: assert property ($past(ce_in) && $past(fault_pending_out)
      && !$past(clr_wr) |-> !dma_fault_event_out)
      else $error("second fault raised an event");
   dma_capture_a: assert property (dma_fault_event_out
      |-> fault_pending_out && acc_ack_out && !acc_grant_out)
      else $error("dma event without capture");
   cpu_cause_a: assert property (cpu_fault_event_out
      |-> $past(loc_req) || $past(reg_req_in))
      else $error("cpu event without local cause");
   clear_record_a: assert property (ce_in && clr_wr && !acc_req_in
      |=> !fault_pending_out)
      else $error("fault record not cleared");
endmodule

bind program_memory_protection_regs program_memory_protection_regs_checker u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_req_in(reg_req_in),
   .reg_write_in(reg_write_in), .reg_super_in(reg_super_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_ack_out(reg_ack_out), .reg_err_out(reg_err_out),
   .reg_rdata_out(reg_rdata_out), .acc_req_in(acc_req_in), .acc_local_in(acc_local_in),
   .acc_ack_out(acc_ack_out), .acc_grant_out(acc_grant_out),
   .cpu_fault_event_out(cpu_fault_event_out), .dma_fault_event_out(dma_fault_event_out),
   .lock_engaged_out(lock_engaged_out), .fault_pending_out(fault_pending_out)
);
